//--- design/eiu_top.sv
// Operation
// - Pin activity raises requests even when the pins are driven as outputs.
// - Any toggle on a selected change-watch pin raises the change request.
// - Change events are seen without the I/O clock and wake the part.
// - Enabled level sensing requests while the pin is low in run mode, not in sleep or start-up.
// - Sixth-pin edges are recognised only while the I/O clock runs.
// - Low levels and low-pin edges are seen in deep sleep and wake the part.
// - The I/O clock stops in every sleep mode except Idle.
// - A level gone before start-up ends wakes the part without an interrupt.
// - Low sense control holds four two-bit selectors, pin 3 on top, reset zero.
// - Low-pin interrupts need global enable and the pin's mask bit.
// - Selector 00 low, 01 any edge, 10 falling, 11 rising.
// - Any low-pin pulse longer than 50 ns raises an interrupt.
// - Edge pending flags set on events, clear on service or one; zero in level mode.
// - Mask register has enables at bits 6 and 3 to 0, reset zero.
// - Sixth pin is sampled before edge detection, same selector encoding.
// - Change interrupt needs group enable and global enable; flag clears on service or one.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
module eiu_top
  import eiu_pkg::*;
#(
  parameter logic [eiu_pkg::STUP_W-1:0] STARTUP_CYC = eiu_pkg::STARTUP_CYC_DEF
) (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  // APB slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [eiu_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [eiu_pkg::DATA_W-1:0]  PWDATA,
  output logic      [eiu_pkg::DATA_W-1:0]  PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // Core side
  input  wire logic                        CORE_STATUS_WORD_GIE,
  input  wire logic [eiu_pkg::N_EXT-1:0]   EXT_IRQ_ACK,
  output logic      [eiu_pkg::N_EXT-1:0]   EXT_IRQ_REQ,
  input  wire logic                        CHANGE_GROUP_ACK,
  output logic                             CHANGE_GROUP_REQUEST,
  // Power control
  input  wire logic                        SLEEP_EN,
  input  wire logic                        SLEEP_IDLE,
  output logic                             IO_CLK_EN,
  output logic                             WAKE,
  // Pins
  input  wire logic [eiu_pkg::N_LOW-1:0]   LOW_EXT_IRQ_PINS,
  input  wire logic                        SIXTH_EXT_IRQ_PIN,
  input  wire logic [eiu_pkg::N_CHG-1:0]   CHANGE_WATCH_PINS
);
  import eiu_pkg::*;
  localparam int NP = N_CHG + N_EXT;

  eiu_state_s       st_q;
  eiu_state_s       st_d;
  logic [NP-1:0]    p_lvl;
  logic [NP-1:0]    p_rise;
  logic [NP-1:0]    p_fall;
  logic [N_EXT-1:0] e_lvl;
  logic [N_EXT-1:0] e_rise;
  logic [N_EXT-1:0] e_fall;
  logic [N_EXT-1:0] e_evt;
  logic [N_EXT-1:0] e_islvl;
  logic [N_EXT-1:0] lvl_req;
  logic [N_CHG-1:0] pc_chg;
  logic [1:0]       sel [N_EXT];
  logic             wr_acc;
  logic             rd_setup;
  logic             hit;
  logic [7:0]       rbyte;
  logic             io_run;

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  // Pads are read directly, whatever the port direction
  eiu_pin_sync #(.W(NP)) eiu_pin_sync_inst (
    .clk  (CLK),
    .rst_n(RST_N),
    .din  ({SIXTH_EXT_IRQ_PIN, LOW_EXT_IRQ_PINS, CHANGE_WATCH_PINS}),
    .lvl  (p_lvl),
    .rise (p_rise),
    .fall (p_fall)
  );

  assign io_run = (st_q.pwr != PWR_SLEEP);
  assign pc_chg = p_rise[N_CHG-1:0] | p_fall[N_CHG-1:0];
  assign e_lvl  = p_lvl[NP-1:N_CHG];
  // Low pins run without the I/O clock; sixth pin needs it
  assign e_rise = {p_rise[NP-1] & io_run, p_rise[NP-2:N_CHG]};
  assign e_fall = {p_fall[NP-1] & io_run, p_fall[NP-2:N_CHG]};

  // ----------------------------------------------------------------
  // Sense decode
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N_EXT; i++) begin : g_ext
      if (i < N_LOW) begin : g_lo
        assign sel[i] = st_q.sns_lo[SNS_W*i +: SNS_W];
      end else begin : g_hi
        assign sel[i] = st_q.sns_hi;
      end
      assign e_islvl[i] = (sel[i] == SENSE_LOW);
      always_comb begin
        unique case (sel[i])
          SENSE_LOW:  e_evt[i] = 1'b0;
          SENSE_ANY:  e_evt[i] = e_rise[i] | e_fall[i];
          SENSE_FALL: e_evt[i] = e_fall[i];
          SENSE_RISE: e_evt[i] = e_rise[i];
        endcase
      end
      // Level request lasts while the pin is low, held off during start-up
      assign lvl_req[i] = e_islvl[i] & ~e_lvl[i] & (st_q.pwr == PWR_RUN);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Requests and wake-up
  // ----------------------------------------------------------------
  always_comb begin
    EXT_IRQ_REQ = {N_EXT{CORE_STATUS_WORD_GIE}} & st_q.msk
                  & (lvl_req | (~e_islvl & st_q.flg));
  end
  assign CHANGE_GROUP_REQUEST = CORE_STATUS_WORD_GIE & st_q.pc_en & st_q.pc_flg;
  assign WAKE = (st_q.pwr == PWR_SLEEP) & CORE_STATUS_WORD_GIE
                & (|(st_q.msk & ((e_islvl & ~e_lvl) | e_evt))
                   | (st_q.pc_en & |(pc_chg & st_q.pc_msk)));
  assign IO_CLK_EN = io_run;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign PREADY   = PSEL & PENABLE;
  assign PRDATA   = st_q.rdata;
  assign PSLVERR  = st_q.slverr & PREADY;
  assign wr_acc   = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;

  always_comb begin
    hit   = 1'b1;
    rbyte = RST_BYTE;
    unique case (PADDR)
      OFS_SENSE_LOW:  rbyte = st_q.sns_lo;
      OFS_SENSE_HIGH: rbyte[SNS_HI_LSB +: SNS_W] = st_q.sns_hi;
      OFS_IRQ_MASK:   rbyte = {1'b0, st_q.msk[SIXTH_IDX], 2'h0, st_q.msk[N_LOW-1:0]};
      OFS_IRQ_FLAGS:  rbyte = {1'b0, st_q.flg[SIXTH_IDX], 2'h0, st_q.flg[N_LOW-1:0]};
      OFS_GROUP_EN:   rbyte[0] = st_q.pc_en;
      OFS_GROUP_PEND: rbyte[0] = st_q.pc_flg;
      OFS_PIN_MASK:   rbyte = st_q.pc_msk;
      OFS_PIN_LEVEL:  rbyte = p_lvl[N_CHG-1:0];
      default:        hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [N_EXT-1:0] w1c;
    logic             pc_w1c;
    st_d   = st_q;
    w1c    = '0;
    pc_w1c = 1'b0;
    if (rd_setup) begin
      st_d.rdata  = {24'h00_0000, rbyte};
      st_d.slverr = ~hit;
    end
    if (wr_acc) begin
      unique case (PADDR)
        OFS_SENSE_LOW:  st_d.sns_lo = PWDATA[7:0];
        OFS_SENSE_HIGH: st_d.sns_hi = PWDATA[SNS_HI_LSB +: SNS_W];
        OFS_IRQ_MASK:   st_d.msk = {PWDATA[SIXTH_BIT], PWDATA[N_LOW-1:0]};
        OFS_IRQ_FLAGS:  w1c = {PWDATA[SIXTH_BIT], PWDATA[N_LOW-1:0]};
        OFS_GROUP_EN:   st_d.pc_en = PWDATA[0];
        OFS_GROUP_PEND: pc_w1c = PWDATA[0];
        OFS_PIN_MASK:   st_d.pc_msk = PWDATA[N_CHG-1:0];
        default:        st_d.pc_en = st_q.pc_en;
      endcase
    end
    // Set wins over clear; level mode forces the flag clear
    st_d.flg = ((st_q.flg & ~w1c & ~EXT_IRQ_ACK) | e_evt) & ~e_islvl;
    st_d.pc_flg = (st_q.pc_flg & ~pc_w1c & ~CHANGE_GROUP_ACK)
                  | |(pc_chg & st_q.pc_msk);
    unique case (st_q.pwr)
      PWR_RUN: begin
        if (SLEEP_EN && !SLEEP_IDLE) begin
          st_d.pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (!SLEEP_EN) begin
          st_d.pwr = PWR_START;
          st_d.cnt = STARTUP_CYC;
        end
      end
      PWR_START: begin
        st_d.cnt = st_q.cnt - CNT_ONE;
        if (st_q.cnt <= CNT_ONE) begin
          st_d.pwr = PWR_RUN;
          st_d.cnt = CNT_ZERO;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '{sns_lo: RST_BYTE, sns_hi: '0, msk: '0, flg: '0, pc_en: 1'b0,
                pc_flg: 1'b0, pc_msk: RST_BYTE, pwr: PWR_RUN, cnt: CNT_ZERO,
                rdata: RD_ZERO, slverr: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_level_hold;
    @(posedge CLK) disable iff (!RST_N)
    (CORE_STATUS_WORD_GIE && st_q.msk[0] && sel[0] == SENSE_LOW && !e_lvl[0]
     && st_q.pwr == PWR_RUN) |-> EXT_IRQ_REQ[0];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level request missing");

  property p_level_noflag;
    @(posedge CLK) disable iff (!RST_N)
    (sel[0] == SENSE_LOW) |=> !st_q.flg[0];
  endproperty
  a_level_noflag: assert property (p_level_noflag) else $error("flag set in level mode");

  property p_fall_path;
    @(posedge CLK) disable iff (!RST_N)
    (sel[0] == SENSE_FALL && $fell(LOW_EXT_IRQ_PINS[0])) ##1 (sel[0] == SENSE_FALL)[*2]
    |=> st_q.flg[0];
  endproperty
  a_fall_path: assert property (p_fall_path) else $error("falling edge not flagged");

  property p_rise_only;
    @(posedge CLK) disable iff (!RST_N)
    (sel[1] == SENSE_RISE && !st_q.flg[1] && !e_rise[1]) |=> !st_q.flg[1];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("flag without rising edge");

  property p_pc_set;
    @(posedge CLK) disable iff (!RST_N)
    (|(pc_chg & st_q.pc_msk)) |=> st_q.pc_flg ##0 $past(st_q.pc_msk) == st_q.pc_msk;
  endproperty
  a_pc_set: assert property (p_pc_set) else $error("change flag not set");

  property p_six_sleep;
    @(posedge CLK) disable iff (!RST_N)
    (st_q.pwr == PWR_SLEEP && !st_q.flg[SIXTH_IDX] && sel[SIXTH_IDX] != SENSE_LOW)
    |=> !st_q.flg[SIXTH_IDX];
  endproperty
  a_six_sleep: assert property (p_six_sleep) else $error("sixth edge seen asleep");

  property p_clk_stop;
    @(posedge CLK) disable iff (!RST_N)
    (st_q.pwr == PWR_RUN && SLEEP_EN && !SLEEP_IDLE) |=> !IO_CLK_EN ##1 (SLEEP_EN ? !IO_CLK_EN : 1'b1);
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock kept in deep sleep");

  property p_startup;
    @(posedge CLK) disable iff (!RST_N)
    (st_q.pwr == PWR_SLEEP && !SLEEP_EN) |=> (st_q.pwr == PWR_START && !(|lvl_req))[*2];
  endproperty
  a_startup: assert property (p_startup) else $error("level request in start-up");

  property p_gie;
    @(posedge CLK) disable iff (!RST_N)
    !CORE_STATUS_WORD_GIE |-> (EXT_IRQ_REQ == '0) && !CHANGE_GROUP_REQUEST && !WAKE;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");

  property p_w0;
    @(posedge CLK) disable iff (!RST_N)
    (wr_acc && PADDR == OFS_IRQ_FLAGS && !PWDATA[0] && !EXT_IRQ_ACK[0]
     && st_q.flg[0] && sel[0] != SENSE_LOW && $stable(sel[0])) |=> st_q.flg[0];
  endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared a flag");

  property p_wake_pc;
    @(posedge CLK) disable iff (!RST_N)
    (st_q.pwr == PWR_SLEEP && CORE_STATUS_WORD_GIE && st_q.pc_en
     && |(pc_chg & st_q.pc_msk)) |-> WAKE;
  endproperty
  a_wake_pc: assert property (p_wake_pc) else $error("change did not wake");

  c_fall_flag: cover property (@(posedge CLK) disable iff (!RST_N)
    sel[0] == SENSE_FALL && $rose(st_q.flg[0]));
  c_pc_flag: cover property (@(posedge CLK) disable iff (!RST_N) $rose(st_q.pc_flg));
  c_wake: cover property (@(posedge CLK) disable iff (!RST_N) WAKE);
  c_start_done: cover property (@(posedge CLK) disable iff (!RST_N)
    st_q.pwr == PWR_START ##1 st_q.pwr == PWR_RUN);
endmodule // eiu_top

//--- design/eiu_pkg.sv
package eiu_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_SENSE_LOW   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SENSE_HIGH  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_GROUP_EN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GROUP_PEND  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PIN_MASK    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL   = 8'h1c;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int N_LOW     = 4;
  localparam int N_EXT     = 5;
  localparam int N_CHG     = 8;
  localparam int SNS_W     = 2;
  localparam int SNS_HI_LSB = 4;
  localparam int SIXTH_BIT = 6;
  localparam int SIXTH_IDX = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Sense selector encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 8;
  localparam int T_INT_NS  = 50;
  localparam int PULSE_CYC = (T_INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STUP_W    = 8;
  localparam logic [STUP_W-1:0] STARTUP_CYC_DEF = 8'h10;
  localparam logic [STUP_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [STUP_W-1:0] CNT_ONE  = 8'h01;
  // ----------------------------------------------------------------
  // Power states and block state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_START} eiu_pwr_e;
  typedef struct packed {
    logic [7:0]        sns_lo;
    logic [SNS_W-1:0]  sns_hi;
    logic [N_EXT-1:0]  msk;
    logic [N_EXT-1:0]  flg;
    logic              pc_en;
    logic              pc_flg;
    logic [N_CHG-1:0]  pc_msk;
    eiu_pwr_e          pwr;
    logic [STUP_W-1:0] cnt;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } eiu_state_s;
endpackage

//--- design/eiu_pin_sync.sv
`timescale 1ns/1ns
module eiu_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins and results
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } eiu_sync_s;
  eiu_sync_s st_q;
  eiu_sync_s st_d;
  // ----------------------------------------------------------------
  // Two-stage synchroniser and edge history
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign lvl[i]  = st_q.s2[i];
      assign rise[i] = st_q.s2[i] & ~st_q.s3[i];
      assign fall[i] = ~st_q.s2[i] & st_q.s3[i];
    end
  endgenerate
endmodule // eiu_pin_sync

//--- tb/eiu_pin_model.sv
`timescale 1ns/1ns
module eiu_pin_model (
  // Clock
  input  wire logic                      clk,
  // Board pins, idle high
  output logic     [eiu_pkg::N_LOW-1:0]  low_pins,
  output logic                           sixth_pin,
  output logic     [eiu_pkg::N_CHG-1:0]  chg_pins
);
  import eiu_pkg::*;
  initial begin
    low_pins = '1;
    sixth_pin = 1'b1;
    chg_pins = '1;
  end
  task automatic set_low(input int idx, input logic v);
    @(posedge clk);
    low_pins[idx] <= v;
  endtask
  // Level is held the whole count before release
  task automatic hold_low(input int idx, input int n);
    set_low(idx, 1'b0);
    repeat (n) @(posedge clk);
    set_low(idx, 1'b1);
  endtask
  task automatic set_sixth(input logic v);
    @(posedge clk);
    sixth_pin <= v;
  endtask
  task automatic toggle_chg(input int idx);
    @(posedge clk);
    chg_pins[idx] <= ~chg_pins[idx];
  endtask
endmodule // eiu_pin_model

//--- tb/test_eiu_top.sv
`timescale 1ns/1ns
module test_eiu_top;
  import eiu_pkg::*;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic              gie, chg_ack, chg_req, sleep_en, sleep_idle, io_clk_en, wake, sixth_pin, fe;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [N_EXT-1:0]  ext_ack, ext_req;
  logic [N_LOW-1:0]  low_pins;
  logic [N_CHG-1:0]  chg_pins;
  int                error_cnt = 0;
  int                n_tests = 0;
  int                cyc = 0;

  eiu_top #(.STARTUP_CYC(8'h08)) eiu_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CORE_STATUS_WORD_GIE(gie), .EXT_IRQ_ACK(ext_ack),
    .EXT_IRQ_REQ(ext_req), .CHANGE_GROUP_ACK(chg_ack), .CHANGE_GROUP_REQUEST(chg_req),
    .SLEEP_EN(sleep_en), .SLEEP_IDLE(sleep_idle), .IO_CLK_EN(io_clk_en), .WAKE(wake),
    .LOW_EXT_IRQ_PINS(low_pins), .SIXTH_EXT_IRQ_PIN(sixth_pin), .CHANGE_WATCH_PINS(chg_pins));
  eiu_pin_model eiu_pin_model_inst (.clk(clk), .low_pins(low_pins), .sixth_pin(sixth_pin),
    .chg_pins(chg_pins));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ack(input logic [N_EXT-1:0] e, input logic c);
    ext_ack <= e;
    chg_ack <= c;
    cw(1);
    ext_ack <= '0;
    chg_ack <= 1'b0;
  endtask
  task automatic pwr_ctl(input logic en, input logic idle);
    sleep_en <= en;
    sleep_idle <= idle;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, '0);
    chk(s, rd, e);
  endtask
  task automatic arm(input logic [7:0] sns, input logic [7:0] msk);
    wr(OFS_IRQ_MASK, '0);
    wr(OFS_SENSE_LOW, {24'h0, sns});
    wr(OFS_IRQ_FLAGS, 32'h4f);
    wr(OFS_IRQ_MASK, {24'h0, msk});
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, gie, chg_ack, sleep_en, sleep_idle} = '0;
    paddr = '0;
    pwdata = '0;
    ext_ack = '0;
    cw(12);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rc("reset", ADDR_W'(4 * i), '0);
    rc("pin levels", OFS_PIN_LEVEL, 32'hff);
    wr(OFS_SENSE_LOW, '1);
    rc("sense low", OFS_SENSE_LOW, 32'hff);
    wr(OFS_IRQ_MASK, '1);
    rc("mask", OFS_IRQ_MASK, 32'h4f);
    rc("unmapped", 8'h20, '0);
    chk("slverr", {31'h0, err}, 32'h1);
    gie <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      arm(8'(m), 8'h01);
      eiu_pin_model_inst.set_low(0, 1'b0);
      cw(4);
      fe = (m == 1 || m == 2);
      chk("req fall", {27'h0, ext_req}, {31'h0, fe});
      wr(OFS_IRQ_FLAGS, '0);
      rc("flag fall", OFS_IRQ_FLAGS, {31'h0, fe});
      wr(OFS_IRQ_FLAGS, 32'h1);
      rc("flag w1c", OFS_IRQ_FLAGS, '0);
      eiu_pin_model_inst.set_low(0, 1'b1);
      cw(3);
      rc("flag rise", OFS_IRQ_FLAGS, {31'h0, m == 1 || m == 3});
    end
    arm(8'h00, 8'h01);
    eiu_pin_model_inst.set_low(0, 1'b0);
    cw(3);
    chk("level req", {27'h0, ext_req}, 32'h1);
    cw(6);
    chk("level held", {27'h0, ext_req}, 32'h1);
    rc("level flag", OFS_IRQ_FLAGS, '0);
    gie <= 1'b0;
    cw(1);
    chk("no gie", {27'h0, ext_req}, '0);
    gie <= 1'b1;
    eiu_pin_model_inst.set_low(0, 1'b1);
    arm(8'haa, 8'h01);
    eiu_pin_model_inst.hold_low(3, 7);
    eiu_pin_model_inst.hold_low(0, 7);
    cw(3);
    chk("masked req", {27'h0, ext_req}, 32'h1);
    rc("pulse flags", OFS_IRQ_FLAGS, 32'h09);
    ack(5'h01, 1'b0);
    cw(1);
    rc("ack flag", OFS_IRQ_FLAGS, 32'h08);
    wr(OFS_PIN_MASK, 32'h04);
    wr(OFS_GROUP_EN, 32'h1);
    eiu_pin_model_inst.toggle_chg(5);
    cw(3);
    rc("unselected", OFS_GROUP_PEND, '0);
    eiu_pin_model_inst.toggle_chg(2);
    cw(3);
    rc("change pend", OFS_GROUP_PEND, 32'h1);
    chk("change req", {31'h0, chg_req}, 32'h1);
    wr(OFS_GROUP_PEND, '0);
    rc("pend keep", OFS_GROUP_PEND, 32'h1);
    ack(5'h00, 1'b1);
    rc("pend ack", OFS_GROUP_PEND, '0);
    wr(OFS_SENSE_HIGH, 32'h20);
    arm(8'h00, 8'h41);
    eiu_pin_model_inst.set_sixth(1'b0);
    cw(4);
    chk("sixth req", {27'h0, ext_req}, 32'h10);
    ack(5'h10, 1'b0);
    eiu_pin_model_inst.set_sixth(1'b1);
    cw(3);
    chk("sixth ack", {27'h0, ext_req}, '0);
    pwr_ctl(1'b1, 1'b1);
    cw(2);
    chk("idle clk", {31'h0, io_clk_en}, 32'h1);
    pwr_ctl(1'b1, 1'b0);
    cw(2);
    chk("deep clk", {31'h0, io_clk_en}, '0);
    eiu_pin_model_inst.set_sixth(1'b0);
    cw(3);
    eiu_pin_model_inst.set_sixth(1'b1);
    cw(3);
    chk("no wake", {31'h0, wake}, '0);
    eiu_pin_model_inst.toggle_chg(2);
    eiu_pin_model_inst.set_low(0, 1'b0);
    cw(3);
    chk("wake", {31'h0, wake}, 32'h1);
    pwr_ctl(1'b0, 1'b0);
    cw(2);
    chk("start req", {27'h0, ext_req}, '0);
    eiu_pin_model_inst.set_low(0, 1'b1);
    cw(10);
    chk("run clk", {31'h0, io_clk_en}, 32'h1);
    chk("woke req", {27'h0, ext_req}, '0);
    rc("woke flags", OFS_IRQ_FLAGS, '0);
    rc("sleep change", OFS_GROUP_PEND, 32'h1);
    summarize();
  end
endmodule // test_eiu_top
